// >>> core/serdes_ctl.sv
// Top of the serdes device-control block: enable latches, parity, selects.
`timescale 1ns/1ps
`default_nettype none
module serdes_ctl #(
  parameter logic [serdes_ctl_pkg::MAP_W-1:0] OE_MAP [4] = '{3'd0, 3'd1, 3'd2, 3'd3},
  parameter logic [serdes_ctl_pkg::MAP_W-1:0] TXT_MAP [4] = '{3'd0, 3'd1, 3'd2, 3'd3},
  parameter logic [serdes_ctl_pkg::MAP_W-1:0] RXT_MAP [4] = '{3'd4, 3'd5, 3'd6, 3'd7},
  parameter logic [serdes_ctl_pkg::MAP_W-1:0] RXP_MAP [4] = '{3'd0, 3'd1, 3'd2, 3'd3}
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic device_reset_n,
  // Enable bus and latch opens
  input wire logic [serdes_ctl_pkg::ENABLE_W-1:0] shared_enable_bus,
  input wire logic output_enable_latch_open,
  input wire logic selftest_latch_open,
  input wire logic rx_power_latch_open,
  // Static selects
  input wire serdes_ctl_pkg::level_t parity_mode_select,
  input wire serdes_ctl_pkg::level_t serial_rate_range_select,
  input wire logic half_rate_reference_clock_in_option,
  input wire logic tx_interface_clock_select,
  input wire logic [serdes_ctl_pkg::CHANNELS-1:0] primary_input_select,
  // Parallel data
  input wire serdes_ctl_pkg::tx_lane_t [serdes_ctl_pkg::CHANNELS-1:0] tx_lane,
  input wire serdes_ctl_pkg::rx_lane_t [serdes_ctl_pkg::CHANNELS-1:0] rx_lane,
  // Serial side
  input wire logic [serdes_ctl_pkg::CHANNELS-1:0] serial_input_pair,
  output logic [serdes_ctl_pkg::CHANNELS-1:0] cdr_serial_in,
  output logic [serdes_ctl_pkg::CHANNELS-1:0] cdr_input_valid,
  // Results
  output serdes_ctl_pkg::chan_ctl_t chan_ctl,
  output logic [serdes_ctl_pkg::CHANNELS-1:0] tx_parity_error,
  output logic [serdes_ctl_pkg::CHANNELS-1:0] rx_parity_bit_out,
  output logic [serdes_ctl_pkg::CHANNELS-1:0] rx_parity_oe,
  output serdes_ctl_pkg::rate_range_t tx_rate_range,
  output serdes_ctl_pkg::rate_range_t rx_rate_range,
  output logic tx_clock_from_reference_clock_in,
  output logic rate_combo_invalid
);
  import serdes_ctl_pkg::*;
  logic [ENABLE_W-1:0] oe_value;
  logic [ENABLE_W-1:0] st_value;
  logic [ENABLE_W-1:0] rxp_value;
  logic dev_clear;
  logic st_clear;
  chan_ctl_t ctl_next;
  rate_range_t range_next;

  // Device reset is a plain pin sampled on the clock edge.
  assign dev_clear = ~device_reset_n;
  // Selftest latch is only cleared while closed, so an open latch keeps its bus.
  assign st_clear = dev_clear & ~selftest_latch_open;

  enable_latch #(.RESET_VALUE(LATCH_RESET)) oe_latch (
    .clock(clock),
    .rst(rst),
    .sync_clear(dev_clear),
    .open_in(output_enable_latch_open),
    .bus_in(shared_enable_bus),
    .value(oe_value)
  );
  enable_latch #(.RESET_VALUE(SELFTEST_RESET)) st_latch (
    .clock(clock),
    .rst(rst),
    .sync_clear(st_clear),
    .open_in(selftest_latch_open),
    .bus_in(shared_enable_bus),
    .value(st_value)
  );
  enable_latch #(.RESET_VALUE(LATCH_RESET)) rxp_latch (
    .clock(clock),
    .rst(rst),
    .sync_clear(dev_clear),
    .open_in(rx_power_latch_open),
    .bus_in(shared_enable_bus),
    .value(rxp_value)
  );

  always_comb begin
    ctl_next = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      ctl_next.out_enable[c] = oe_value[OE_MAP[c]];
      ctl_next.tx_normal[c] = st_value[TXT_MAP[c]];
      ctl_next.rx_normal[c] = st_value[RXT_MAP[c]];
      ctl_next.rx_power[c] = rxp_value[RXP_MAP[c]];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chan_ctl <= '{out_enable: '0, tx_normal: '1, rx_normal: '1, rx_power: '0};
    end else begin
      chan_ctl <= ctl_next;
    end
  end

  always_comb begin
    unique case (serial_rate_range_select)
      LEVEL_LOW: range_next = RANGE_LOW;
      LEVEL_MID: range_next = RANGE_MID;
      LEVEL_HIGH: range_next = RANGE_HIGH;
      default: range_next = RANGE_MID;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_rate_range <= RANGE_LOW;
      rx_rate_range <= RANGE_LOW;
      rate_combo_invalid <= 1'b0;
      tx_clock_from_reference_clock_in <= 1'b1;
    end else begin
      tx_rate_range <= range_next;
      rx_rate_range <= range_next;
      // Flagged only; the host is expected never to set this pair.
      rate_combo_invalid <= half_rate_reference_clock_in_option && serial_rate_range_select == LEVEL_LOW;
      tx_clock_from_reference_clock_in <= ~tx_interface_clock_select;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cdr_serial_in <= '0;
      cdr_input_valid <= '0;
    end else begin
      cdr_serial_in <= serial_input_pair & primary_input_select;
      cdr_input_valid <= primary_input_select;
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_lane
    parity_lane lane (
      .clock(clock),
      .rst(rst),
      .mode(parity_mode_select),
      .tx_in(tx_lane[c]),
      .rx_in(rx_lane[c]),
      .tx_error(tx_parity_error[c]),
      .rx_parity(rx_parity_bit_out[c]),
      .rx_parity_oe(rx_parity_oe[c])
    );
  end
endmodule
`default_nettype wire

// >>> core/serdes_ctl_pkg.sv
// Package of constants and types for the serdes device-control block.
// Function
// - Middle parity: check tx odd, generate rx odd.
// - High parity: rx parity includes comma flag.
// - Low parity: no checks, rx parity floats.
// - Clock select low: tx interface uses reference_clock_in.
// - Rate select decodes low, middle, high ranges.
// - Primary serial input reaches recovery when selected.
// - Output enable latch transparent while open.
// - High bit enables driver, low powers down.
// - Output enable latch holds value on close.
// - Reset clears output enables, drivers off.
// - Selftest latch transparent while open.
// - Low bit selects selftest, high normal traffic.
// - Selftest latch holds value on close.
// - Reset sets selftest latch to all ones, selftest disabled.
// - Rx power latch transparent, high bit powers.
// - Rx power latch holds value on close.
// - Reset clears rx power latch, channels off.
// - Reset sampled on clock, clears oe and rx power latches, sets selftest latch only while closed.
package serdes_ctl_pkg;
  localparam int CHANNELS = 4;
  localparam int WORD_W = 10;
  localparam int ENABLE_W = 8;
  localparam int MAP_W = 3;
  localparam logic [ENABLE_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [ENABLE_W-1:0] SELFTEST_RESET = 8'hFF;
  localparam int RATE_LOW_MIN_MBAUD = 195;
  localparam int RATE_LOW_MAX_MBAUD = 400;
  localparam int RATE_MID_MAX_MBAUD = 800;
  localparam int RATE_HIGH_MAX_MBAUD = 1500;
  typedef enum logic [1:0] {LEVEL_LOW, LEVEL_MID, LEVEL_HIGH} level_t;
  typedef enum logic [1:0] {RANGE_LOW, RANGE_MID, RANGE_HIGH} rate_range_t;
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic parity;
  } tx_lane_t;
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic comma;
  } rx_lane_t;
  typedef struct packed {
    logic [CHANNELS-1:0] out_enable;
    logic [CHANNELS-1:0] tx_normal;
    logic [CHANNELS-1:0] rx_normal;
    logic [CHANNELS-1:0] rx_power;
  } chan_ctl_t;
  function automatic logic odd_fill(input logic [WORD_W:0] bits);
    odd_fill = ~(^bits);
  endfunction
endpackage

// >>> core/enable_latch.sv
// Clock-sampled enable latch, transparent while open, holding when closed.
`timescale 1ns/1ps
`default_nettype none
module enable_latch #(
  parameter logic [serdes_ctl_pkg::ENABLE_W-1:0] RESET_VALUE = 8'h00
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic sync_clear,
  // Latch control
  input wire logic open_in,
  input wire logic [serdes_ctl_pkg::ENABLE_W-1:0] bus_in,
  // Effective value
  output logic [serdes_ctl_pkg::ENABLE_W-1:0] value
);
  import serdes_ctl_pkg::*;
  logic [ENABLE_W-1:0] held_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held_reg <= RESET_VALUE;
    end else if (sync_clear) begin
      held_reg <= RESET_VALUE;
    end else if (open_in) begin
      held_reg <= bus_in;
    end
  end
  // Open passes the bus straight through; closing keeps the last sample.
  assign value = sync_clear ? RESET_VALUE : (open_in ? bus_in : held_reg);
endmodule
`default_nettype wire

// >>> core/parity_lane.sv
// Per-channel odd parity check and generate lane.
`timescale 1ns/1ps
`default_nettype none
module parity_lane (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Mode
  input wire serdes_ctl_pkg::level_t mode,
  // Data
  input wire serdes_ctl_pkg::tx_lane_t tx_in,
  input wire serdes_ctl_pkg::rx_lane_t rx_in,
  // Results
  output logic tx_error,
  output logic rx_parity,
  output logic rx_parity_oe
);
  import serdes_ctl_pkg::*;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_error <= 1'b0;
    end else begin
      tx_error <= (mode != LEVEL_LOW) && !(^{tx_in.word, tx_in.parity});
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_parity <= 1'b0;
      rx_parity_oe <= 1'b0;
    end else begin
      rx_parity_oe <= (mode != LEVEL_LOW);
      if (mode == LEVEL_HIGH) begin
        rx_parity <= odd_fill({rx_in.word, rx_in.comma});
      end else begin
        rx_parity <= odd_fill({rx_in.word, 1'b0});
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/serdes_ctl_assertions.sv
// Checker for the serdes control block's latches, parity mode and selects.
`timescale 1ns/1ps
`default_nettype none
module serdes_ctl_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic device_reset_n,
  // Controls
  input wire logic [7:0] shared_enable_bus,
  input wire logic output_enable_latch_open,
  input wire logic selftest_latch_open,
  input wire logic rx_power_latch_open,
  input wire serdes_ctl_pkg::level_t parity_mode_select,
  input wire serdes_ctl_pkg::level_t serial_rate_range_select,
  // Results
  input wire serdes_ctl_pkg::chan_ctl_t chan_ctl,
  input wire logic [3:0] tx_parity_error,
  input wire logic [3:0] rx_parity_oe,
  input wire serdes_ctl_pkg::rate_range_t rx_rate_range
);
  import serdes_ctl_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  a_oe_follow: assert property (
    output_enable_latch_open && device_reset_n
    |=> chan_ctl.out_enable == $past(shared_enable_bus[3:0])) else $error("oe follow");
  a_oe_hold: assert property (
    !output_enable_latch_open && device_reset_n |=> $stable(chan_ctl.out_enable))
    else $error("oe hold");
  a_reset_clears: assert property (
    !device_reset_n |=> chan_ctl.out_enable == 4'h0 && chan_ctl.rx_power == 4'h0)
    else $error("reset clear");
  a_st_follow: assert property (
    selftest_latch_open |=> {chan_ctl.tx_normal, chan_ctl.rx_normal}
    == {$past(shared_enable_bus[3:0]), $past(shared_enable_bus[7:4])}) else $error("st");
  a_st_clear: assert property (
    !device_reset_n && !selftest_latch_open
    |=> chan_ctl.tx_normal == 4'hF && chan_ctl.rx_normal == 4'hF) else $error("st clear");
  a_rxp_follow: assert property (
    rx_power_latch_open && device_reset_n
    |=> chan_ctl.rx_power == $past(shared_enable_bus[3:0])) else $error("rxp follow");
  a_parity_off: assert property (
    parity_mode_select == LEVEL_LOW |=> rx_parity_oe == 4'h0 && tx_parity_error == 4'h0)
    else $error("parity off");
  a_rate_high: assert property (
    serial_rate_range_select == LEVEL_HIGH |=> rx_rate_range == RANGE_HIGH)
    else $error("rate");
  c_oe_close: cover property (output_enable_latch_open ##1 !output_enable_latch_open);
  c_dev_reset: cover property (!device_reset_n);
  c_par_high: cover property (parity_mode_select == LEVEL_HIGH);
  c_st_keep: cover property (!device_reset_n && selftest_latch_open);
endmodule
bind serdes_ctl serdes_ctl_assertions u_checker (.clock, .rst, .device_reset_n,
  .shared_enable_bus, .output_enable_latch_open, .selftest_latch_open,
  .rx_power_latch_open, .parity_mode_select, .serial_rate_range_select, .chan_ctl,
  .tx_parity_error, .rx_parity_oe, .rx_rate_range);
`default_nettype wire

// >>> bench/host_model.sv
// Host logic model that loads the enable latches over the shared bus.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clock,
  // Host pins
  output logic [7:0] shared_enable_bus,
  output logic [2:0] latch_open,
  output logic half_rate_reference_clock_in_option
);
  initial begin
    shared_enable_bus = 8'h00;
    latch_open = 3'h0;
    half_rate_reference_clock_in_option = 1'b0;
  end
  // The bus is held past the close so the captured value is unambiguous.
  task automatic load(input int which, input logic [7:0] val);
    @(posedge clock);
    shared_enable_bus <= val;
    latch_open[which] <= 1'b1;
    @(posedge clock);
    latch_open[which] <= 1'b0;
    @(posedge clock);
    shared_enable_bus <= ~val;
  endtask
  // Open one latch with a bus value and leave it open until closed.
  task automatic open_latch(input int which, input logic [7:0] val);
    shared_enable_bus <= val;
    latch_open[which] <= 1'b1;
  endtask
  task automatic close_latch(input int which);
    latch_open[which] <= 1'b0;
  endtask
  // The half rate option is only raised at a middle or high serial rate.
  task automatic set_half_rate(input logic val);
    half_rate_reference_clock_in_option <= val;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_serdes_ctl.sv
// Self-checking bench for the serdes device-control block.
`timescale 1ns/1ps
`default_nettype none
module tb_serdes_ctl;
  import serdes_ctl_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic device_reset_n = 1'b1;
  logic [7:0] shared_enable_bus;
  logic [2:0] latch_open;
  logic half_rate_reference_clock_in_option;
  level_t parity_mode_select = LEVEL_MID;
  level_t serial_rate_range_select = LEVEL_LOW;
  logic tx_interface_clock_select = 1'b0;
  logic [3:0] primary_input_select = 4'h0;
  logic [3:0] serial_input_pair = 4'hB;
  tx_lane_t [3:0] tx_lane = '0;
  rx_lane_t [3:0] rx_lane = '0;
  logic [3:0] cdr_serial_in, cdr_input_valid, tx_parity_error, rx_parity_bit_out, rx_parity_oe;
  chan_ctl_t chan_ctl;
  rate_range_t tx_rate_range, rx_rate_range;
  logic tx_clock_from_reference_clock_in;
  logic rate_combo_invalid;
  int failures = 0;
  int compares = 0;
  initial begin
    forever #12.5 clock = ~clock;
  end
  host_model u_host (.clock, .shared_enable_bus, .latch_open, .half_rate_reference_clock_in_option);
  serdes_ctl u_dut (.clock, .rst, .device_reset_n, .shared_enable_bus,
    .output_enable_latch_open(latch_open[0]), .selftest_latch_open(latch_open[1]),
    .rx_power_latch_open(latch_open[2]), .parity_mode_select, .serial_rate_range_select,
    .half_rate_reference_clock_in_option, .tx_interface_clock_select, .primary_input_select, .tx_lane,
    .rx_lane, .serial_input_pair, .cdr_serial_in, .cdr_input_valid, .chan_ctl,
    .tx_parity_error, .rx_parity_bit_out, .rx_parity_oe, .tx_rate_range, .rx_rate_range,
    .tx_clock_from_reference_clock_in, .rate_combo_invalid);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    @(posedge clock);
    #1;
  endtask
  task automatic test_latches();
    chk(chan_ctl, 16'h0FF0);
    u_host.load(0, 8'hA5);
    settle();
    chk(chan_ctl.out_enable, 16'h5);
    u_host.load(1, 8'h3C);
    settle();
    chk({chan_ctl.tx_normal, chan_ctl.rx_normal}, 16'hC3);
    u_host.load(2, 8'h96);
    settle();
    chk(chan_ctl.rx_power, 16'h6);
    @(posedge clock);
    device_reset_n <= 1'b0;
    @(posedge clock);
    device_reset_n <= 1'b1;
    #1;
    chk(chan_ctl, 16'h0FF0);
    // An open selftest latch ignores device reset and keeps passing the bus.
    @(posedge clock);
    u_host.open_latch(1, 8'h5A);
    device_reset_n <= 1'b0;
    @(posedge clock);
    u_host.close_latch(1);
    device_reset_n <= 1'b1;
    #1;
    chk({chan_ctl.tx_normal, chan_ctl.rx_normal}, 16'hA5);
    chk({chan_ctl.out_enable, chan_ctl.rx_power}, 16'h00);
  endtask
  task automatic test_parity();
    logic [3:0] err_exp[3] = '{4'h0, 4'hA, 4'hA};
    logic [3:0] par_exp[3] = '{4'h0, 4'h0, 4'h3};
    @(posedge clock);
    for (int c = 0; c < 4; c++) begin
      tx_lane[c] <= {10'h3FF, ~c[0]};
      rx_lane[c] <= {10'h001, c < 2};
    end
    for (int m = 0; m < 3; m++) begin
      @(posedge clock);
      parity_mode_select <= level_t'(m);
      settle();
      chk(tx_parity_error, err_exp[m]);
      chk(rx_parity_oe, (m == 0) ? 16'h0 : 16'hF);
      if (m != 0) chk(rx_parity_bit_out, par_exp[m]);
    end
  endtask
  task automatic test_selects();
    rate_range_t rr[3] = '{RANGE_LOW, RANGE_MID, RANGE_HIGH};
    for (int m = 0; m < 3; m++) begin
      @(posedge clock);
      serial_rate_range_select <= level_t'(m);
      tx_interface_clock_select <= m[0];
      primary_input_select <= 4'h6 << m;
      u_host.set_half_rate(m != 0);
      settle();
      chk(rate_combo_invalid, 16'h0);
      chk({tx_rate_range, rx_rate_range}, {rr[m], rr[m]});
      chk(tx_clock_from_reference_clock_in, !m[0]);
      chk({cdr_input_valid, cdr_serial_in}, {4'h6 << m, (4'h6 << m) & 4'hB});
    end
  endtask
  task automatic end_of_test();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    settle();
    test_latches();
    test_parity();
    test_selects();
    end_of_test();
  end
  // The tests need about 35 cycles; this margin covers a stuck wait.
  initial begin
    #50000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
